/* tcc_pkg.sv */
// Package: register map, field layouts and reset values of the capture/compare block
package tcc_pkg;

  // ----------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------
  // Printed offsets are not all multiples of four: they are register indices.
  localparam logic [15:0] IDX_CAPTURE_TIME_1 = 16'h1010;
  localparam logic [15:0] IDX_CAPTURE_TIME_2 = 16'h1012;
  localparam logic [15:0] IDX_CAPTURE_TIME_3 = 16'h1014;
  localparam logic [15:0] IDX_COMPARE_VALUE_1 = 16'h1016;
  localparam logic [15:0] IDX_COMPARE_VALUE_2 = 16'h1018;
  localparam logic [15:0] IDX_COMPARE_VALUE_3 = 16'h101A;
  localparam logic [15:0] IDX_COMPARE_VALUE_4 = 16'h101C;
  localparam logic [15:0] IDX_SHARED_VALUE = 16'h101E;
  localparam logic [15:0] IDX_PIN_ACTION = 16'h1020;
  localparam logic [15:0] IDX_CAPTURE_EDGE = 16'h1021;
  localparam logic [15:0] IDX_IRQ_ENABLE = 16'h1022;
  localparam logic [15:0] IDX_EVENT_FLAGS = 16'h1023;
  localparam logic [15:0] IDX_PULSE_ACCUM_CTRL = 16'h1026;
  localparam logic [15:0] IDX_COUNTER = 16'h100E;

  // ----------------------------------------
  // Reset values and field positions
  // ----------------------------------------
  localparam logic [15:0] COMPARE_RESET = 16'hFFFF;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int SHARED_SELECT_BIT = 2;
  // Flag/enable layout: [7:4] compare 1..4, [3] shared, [2:0] capture 1..3
  localparam int FLAG_COMPARE_1 = 7;
  localparam int FLAG_SHARED = 3;
  localparam int FLAG_CAPTURE_1 = 2;

  // Two-bit pin action codes
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_LOW = 2'h2;
  localparam logic [1:0] ACT_HIGH = 2'h3;

  // Two-bit edge select codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;

  typedef struct packed {
    logic [15:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  // Byte address of a register index
  function automatic logic [17:0] reg_addr(input logic [15:0] idx);
    reg_addr = {idx, 2'h0};
  endfunction

endpackage

/* timer_capture_compare_regs.sv */
// Capture/compare channel registers of a 16-bit free-running timer, APB slave
`timescale 1ns/1ps
module timer_capture_compare_regs
  import tcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] free_running_counter,
  input wire logic [3:0] capture_pin,
  output logic [4:0] compare_pin,
  output logic irq
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] capture_time_reg [3];
  logic [15:0] compare_value_reg [4];
  logic [15:0] shared_capture_compare_reg;
  logic [7:0] compare_pin_action_control;
  logic [7:0] capture_edge_control;
  logic [7:0] timer_channel_irq_enable;
  logic [7:0] timer_channel_event_flags;
  logic shared_channel_select;
  logic [1:0] compare1_action;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  apb_req_t req;
  logic access;
  logic wr;
  logic hit;
  assign req = '{paddr: paddr[17:2], pwrite: pwrite, pwdata: pwdata};
  assign access = psel && penable;
  assign wr = access && req.pwrite;

  function automatic logic is_reg(input logic [15:0] idx);
    is_reg = (paddr == reg_addr(idx));
  endfunction

  // ----------------------------------------
  // Write strobes, one per writable register (none for capture times or counter)
  // ----------------------------------------
  logic [3:0] wr_compare;
  logic wr_shared;
  logic wr_pin_action;
  logic wr_capture_edge;
  logic wr_irq_enable;
  logic wr_event_flags;
  logic wr_pulse_ctrl;
  assign wr_compare[0] = wr && is_reg(IDX_COMPARE_VALUE_1);
  assign wr_compare[1] = wr && is_reg(IDX_COMPARE_VALUE_2);
  assign wr_compare[2] = wr && is_reg(IDX_COMPARE_VALUE_3);
  assign wr_compare[3] = wr && is_reg(IDX_COMPARE_VALUE_4);
  // Shared register writes are dropped while the channel captures
  assign wr_shared = wr && is_reg(IDX_SHARED_VALUE) && !shared_channel_select;
  assign wr_pin_action = wr && is_reg(IDX_PIN_ACTION);
  assign wr_capture_edge = wr && is_reg(IDX_CAPTURE_EDGE);
  assign wr_irq_enable = wr && is_reg(IDX_IRQ_ENABLE);
  assign wr_event_flags = wr && is_reg(IDX_EVENT_FLAGS);
  assign wr_pulse_ctrl = wr && is_reg(IDX_PULSE_ACCUM_CTRL);

  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_s3;
  logic [3:0] pin_level;
  logic [3:0] pin_settled;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_s3 <= 4'h0;
    end else begin
      pin_s1 <= capture_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // A pin change counts only once stages two and three agree, so a
  // metastable first stage never produces a capture on its own
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_settled[i] = (pin_s2[i] == pin_s3[i]) ? pin_s3[i] : pin_level[i];
    end
  end

  // Pins that idle high give a false edge after reset; harmless, edge fields reset off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level <= 4'h0;
    end else begin
      pin_level <= pin_settled;
    end
  end

  function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic was);
    unique case (sel)
      EDGE_OFF: edge_hit = 1'b0;
      EDGE_RISE: edge_hit = now && !was;
      EDGE_FALL: edge_hit = !now && was;
      EDGE_ANY: edge_hit = now != was;
    endcase
  endfunction

  // Capture 1..3 edge fields sit in [7:2], capture 4 in [1:0]
  logic [3:0] cap_event;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cap_event[i] = edge_hit(capture_edge_control[7 - 2 * i -: 2], pin_settled[i],
                              pin_level[i]);
    end
    cap_event[3] = cap_event[3] && shared_channel_select;
  end

  // ----------------------------------------
  // Compare matches
  // ----------------------------------------
  logic [4:0] cmp_event;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cmp_event[i] = free_running_counter == compare_value_reg[i];
    end
    cmp_event[4] = !shared_channel_select &&
                   (free_running_counter == shared_capture_compare_reg);
  end

  // ----------------------------------------
  // Capture registers (no reset)
  // ----------------------------------------
  // Not reset: software may still read the last capture after a reset
  always_ff @(posedge pclk) begin
    for (int i = 0; i < 3; i++) begin
      if (cap_event[i]) begin
        capture_time_reg[i] <= free_running_counter;
      end
    end
  end

  // ----------------------------------------
  // Compare value registers 1..4
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        compare_value_reg[i] <= COMPARE_RESET;
      end
    end else begin
      if (wr_compare[0]) begin
        compare_value_reg[0] <= req.pwdata[15:0];
      end
      if (wr_compare[1]) begin
        compare_value_reg[1] <= req.pwdata[15:0];
      end
      if (wr_compare[2]) begin
        compare_value_reg[2] <= req.pwdata[15:0];
      end
      if (wr_compare[3]) begin
        compare_value_reg[3] <= req.pwdata[15:0];
      end
    end
  end

  // ----------------------------------------
  // Shared capture 4 / compare 5 register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_capture_compare_reg <= COMPARE_RESET;
    end else if (shared_channel_select) begin
      if (cap_event[3]) begin
        shared_capture_compare_reg <= free_running_counter;
      end
    end else if (wr_shared) begin
      shared_capture_compare_reg <= req.pwdata[15:0];
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_pin_action_control <= CTRL_RESET;
      compare1_action <= ACT_OFF;
    end else if (wr_pin_action) begin
      compare_pin_action_control <= req.pwdata[7:0];
      compare1_action <= req.pwdata[9:8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_edge_control <= CTRL_RESET;
    end else if (wr_capture_edge) begin
      capture_edge_control <= req.pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_channel_irq_enable <= CTRL_RESET;
    end else if (wr_irq_enable) begin
      timer_channel_irq_enable <= req.pwdata[7:0];
    end
  end

  // Other pulse accumulator bits belong elsewhere; only the select is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_channel_select <= 1'b0;
    end else if (wr_pulse_ctrl) begin
      shared_channel_select <= req.pwdata[SHARED_SELECT_BIT];
    end
  end

  // ----------------------------------------
  // Event flags: hardware set wins over clear
  // ----------------------------------------
  logic [7:0] set_flags;
  logic [7:0] clr_flags;
  always_comb begin
    set_flags = 8'h00;
    for (int i = 0; i < 4; i++) begin
      set_flags[FLAG_COMPARE_1 - i] = cmp_event[i];
    end
    set_flags[FLAG_SHARED] = cmp_event[4] || cap_event[3];
    for (int i = 0; i < 3; i++) begin
      set_flags[FLAG_CAPTURE_1 - i] = cap_event[i];
    end
    clr_flags = wr_event_flags ? req.pwdata[7:0] : 8'h00;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_channel_event_flags <= CTRL_RESET;
    end else begin
      timer_channel_event_flags <= (timer_channel_event_flags & ~clr_flags) | set_flags;
    end
  end

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  logic [7:0] pending;
  assign pending = timer_channel_event_flags & timer_channel_irq_enable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      // Interrupt follows the flags one cycle later so it comes from a flip-flop
      irq <= |pending;
    end
  end

  // ----------------------------------------
  // Compare output pins
  // ----------------------------------------
  function automatic logic pin_next(input logic [1:0] act, input logic cur);
    unique case (act)
      ACT_OFF: pin_next = cur;
      ACT_TOGGLE: pin_next = !cur;
      ACT_LOW: pin_next = 1'b0;
      ACT_HIGH: pin_next = 1'b1;
    endcase
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_pin <= 5'h00;
    end else begin
      if (cmp_event[0]) begin
        compare_pin[0] <= pin_next(compare1_action, compare_pin[0]);
      end
      for (int i = 1; i < 5; i++) begin
        if (cmp_event[i]) begin
          compare_pin[i] <= pin_next(compare_pin_action_control[9 - 2 * i -: 2],
                                     compare_pin[i]);
        end
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [31:0] rd;
  always_comb begin
    hit = 1'b1;
    rd = 32'h00000000;
    unique case (paddr)
      reg_addr(IDX_CAPTURE_TIME_1): rd = {16'h0000, capture_time_reg[0]};
      reg_addr(IDX_CAPTURE_TIME_2): rd = {16'h0000, capture_time_reg[1]};
      reg_addr(IDX_CAPTURE_TIME_3): rd = {16'h0000, capture_time_reg[2]};
      reg_addr(IDX_COMPARE_VALUE_1): rd = {16'h0000, compare_value_reg[0]};
      reg_addr(IDX_COMPARE_VALUE_2): rd = {16'h0000, compare_value_reg[1]};
      reg_addr(IDX_COMPARE_VALUE_3): rd = {16'h0000, compare_value_reg[2]};
      reg_addr(IDX_COMPARE_VALUE_4): rd = {16'h0000, compare_value_reg[3]};
      reg_addr(IDX_SHARED_VALUE): rd = {16'h0000, shared_capture_compare_reg};
      reg_addr(IDX_PIN_ACTION): rd = {22'h0, compare1_action, compare_pin_action_control};
      reg_addr(IDX_CAPTURE_EDGE): rd = {24'h000000, capture_edge_control};
      reg_addr(IDX_IRQ_ENABLE): rd = {24'h000000, timer_channel_irq_enable};
      reg_addr(IDX_EVENT_FLAGS): rd = {24'h000000, timer_channel_event_flags};
      reg_addr(IDX_PULSE_ACCUM_CTRL): rd = {29'h0, shared_channel_select, 2'h0};
      reg_addr(IDX_COUNTER): rd = {16'h0000, free_running_counter};
      default: hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Bus outputs
  // ----------------------------------------
  // No wait state: pready rises in the first access cycle, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // Unmapped addresses are refused; no write strobe matches them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !hit;
    end
  end

  // Read data stands only in the access cycle and is zero otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= (psel && !penable && !pwrite) ? rd : 32'h00000000;
    end
  end

endmodule // timer_capture_compare_regs

/* tcc_sva.sv */
// Assertion checker for the capture/compare register block
`timescale 1ns/1ps
module tcc_sva
  import tcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] free_running_counter,
  input wire logic [3:0] capture_pin,
  input wire logic [4:0] compare_pin,
  input wire logic irq
);
  logic wr;
  logic [7:0] en_q;
  logic [9:0] act_q;
  assign wr = psel && penable && pready && pwrite;
  // Shadows follow completed writes so rules can be tied to register state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en_q <= 8'h00;
    else if (wr && paddr == {IDX_IRQ_ENABLE, 2'h0}) en_q <= pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) act_q <= 10'h000;
    else if (wr && paddr == {IDX_PIN_ACTION, 2'h0}) act_q <= pwdata[9:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  a_ready_after_setup: assert property (setup_s |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (access_s |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_upper_zero: assert property (access_s and !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  a_unmapped_err: assert property (setup_s and paddr == {16'h1030, 2'h0} |=> pslverr)
    else $error("unmapped access not refused");
  a_irq_needs_enable: assert property (en_q == 8'h00 |=> !irq)
    else $error("irq without enable");
  a_off_holds_pin: assert property (act_q[1:0] == ACT_OFF |=> $stable(compare_pin[4]))
    else $error("disabled channel five moved");
  a_ch2_off_holds: assert property (act_q[7:6] == ACT_OFF |=> $stable(compare_pin[1]))
    else $error("disabled channel two moved");
endmodule // tcc_sva

bind timer_capture_compare_regs tcc_sva chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .free_running_counter(free_running_counter),
  .capture_pin(capture_pin), .compare_pin(compare_pin), .irq(irq));

/* tb_top.sv */
// Testbench for the capture/compare register block
`timescale 1ns/1ps
module tb_top;
  import tcc_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [15:0] free_running_counter = '0;
  logic [3:0] capture_pin = '0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, p, hit;
  logic [4:0] compare_pin;
  logic [32:0] exq[$];
  logic [15:0] c, last;
  logic [1:0] code;
  int fail_count = 0, compares = 0;
  always #50 pclk = ~pclk;
  timer_capture_compare_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .free_running_counter(free_running_counter),
    .capture_pin(capture_pin), .compare_pin(compare_pin), .irq(irq));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    compares++;
    if (g !== e) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask
  task results;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Expected {pslverr, data}; writes expect data zero
  task automatic xfer(input logic [15:0] idx, input logic w, input logic [31:0] d,
                      input logic [32:0] e);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    exq.push_back(e);
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      results;
    end
    psel <= 0;
    penable <= 0;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && exq.size() > 0)
      chk(pwrite ? {pslverr, 32'h0} : {pslverr, prdata}, exq.pop_front());
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(42612));
    repeat (16) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 5; i++) xfer(IDX_COMPARE_VALUE_1 + 16'(2 * i), 0, 0, 33'hFFFF);
    xfer(IDX_PIN_ACTION, 0, 0, '0);
    xfer(IDX_IRQ_ENABLE, 0, 0, '0);
    xfer(IDX_EVENT_FLAGS, 0, 0, '0);
    xfer(IDX_PULSE_ACCUM_CTRL, 0, 0, '0);
    $display("test reset_values done");
    // Compare values kept at 8000 or above so capture counts never match them
    for (int i = 0; i < 4; i++) begin
      c = {1'b1, 15'($urandom)};
      xfer(IDX_COMPARE_VALUE_1 + 16'(2 * i), 1, {16'h0, c}, '0);
      xfer(IDX_COMPARE_VALUE_1 + 16'(2 * i), 0, 0, {17'h0, c});
    end
    xfer(16'h1030, 1, 32'h1, {1'b1, 32'h0});
    xfer(IDX_PULSE_ACCUM_CTRL, 1, 32'h4, '0);
    xfer(IDX_SHARED_VALUE, 1, 32'h1234, '0);
    xfer(IDX_SHARED_VALUE, 0, 0, 33'hFFFF);
    xfer(IDX_PULSE_ACCUM_CTRL, 1, 32'h0, '0);
    xfer(IDX_SHARED_VALUE, 1, 32'hABCD, '0);
    xfer(IDX_SHARED_VALUE, 0, 0, 33'hABCD);
    $display("test register_access done");
    xfer(IDX_IRQ_ENABLE, 1, 32'h44, '0);
    xfer(IDX_COMPARE_VALUE_2, 1, 32'h1234, '0);
    p = 0;
    for (int k = 0; k < 4; k++) begin
      code = 2'(k + 1);
      xfer(IDX_PIN_ACTION, 1, {24'h0, code, 6'h0}, '0);
      @(posedge pclk) free_running_counter <= 16'h1234;
      @(posedge pclk) free_running_counter <= 16'h0;
      repeat (3) @(posedge pclk);
      p = code == ACT_TOGGLE ? !p : code == ACT_LOW ? 1'b0 : code == ACT_HIGH ? 1'b1 : p;
      chk({32'h0, compare_pin[1]}, {32'h0, p});
      if (code != ACT_OFF) begin
        chk({32'h0, irq}, 33'h1);
        xfer(IDX_EVENT_FLAGS, 1, 32'h0, '0);
        xfer(IDX_EVENT_FLAGS, 0, 0, 33'h40);
        xfer(IDX_EVENT_FLAGS, 1, 32'h40, '0);
        xfer(IDX_EVENT_FLAGS, 0, 0, '0);
      end
    end
    xfer(IDX_EVENT_FLAGS, 1, 32'hFF, '0);
    $display("test compare_actions done");
    for (int k = 0; k < 4; k++) begin
      code = 2'(k + 1);
      xfer(IDX_CAPTURE_EDGE, 1, {24'h0, code, 6'h0}, '0);
      for (int r = 1; r >= 0; r--) begin
        c = {2'b01, 14'($urandom)};
        @(posedge pclk) begin
          free_running_counter <= c;
          capture_pin[0] <= r[0];
        end
        repeat (6) @(posedge pclk);
        hit = r[0] ? code[0] : code[1];
        if (hit) last = c;
        chk({32'h0, irq}, {32'h0, hit});
        xfer(IDX_EVENT_FLAGS, 0, 0, {30'h0, hit, 2'h0});
        xfer(IDX_CAPTURE_TIME_1, 0, 0, {17'h0, last});
        xfer(IDX_EVENT_FLAGS, 1, 32'hFF, '0);
      end
    end
    $display("test capture_edges done");
    xfer(IDX_PULSE_ACCUM_CTRL, 1, 32'h4, '0);
    xfer(IDX_IRQ_ENABLE, 1, 32'h08, '0);
    xfer(IDX_CAPTURE_EDGE, 1, 32'h1, '0);
    @(posedge pclk) capture_pin[3] <= 1;
    repeat (6) @(posedge pclk);
    chk({32'h0, irq}, 33'h1);
    xfer(IDX_EVENT_FLAGS, 0, 0, 33'h08);
    xfer(IDX_SHARED_VALUE, 0, 0, {17'h0, c});
    $display("test shared_capture done");
    @(posedge pclk) presetn <= 0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    xfer(IDX_CAPTURE_TIME_1, 0, 0, {17'h0, last});
    xfer(IDX_COMPARE_VALUE_2, 0, 0, 33'hFFFF);
    $display("test second_reset done");
    xfer(IDX_COMPARE_VALUE_1, 1, 32'h55, '0);
    xfer(IDX_SHARED_VALUE, 1, 32'h55, '0);
    xfer(IDX_PIN_ACTION, 1, 32'h303, '0);
    xfer(IDX_IRQ_ENABLE, 1, 32'h88, '0);
    @(posedge pclk) free_running_counter <= 16'h0055;
    @(posedge pclk) free_running_counter <= 16'h0;
    repeat (3) @(posedge pclk);
    chk({31'h0, compare_pin[4], compare_pin[0]}, 33'h3);
    chk({32'h0, irq}, 33'h1);
    xfer(IDX_EVENT_FLAGS, 0, 0, 33'h88);
    $display("test compare_one_five done");
    results;
  end
endmodule // tb_top
